/* rtl/acr_pkg.sv */
// acr_pkg: register map, field layout, reset values and timing for the converter control block
package acr_pkg;

  // direct-page registers
  localparam logic [15:0] ADDR_STATUS_CHANNEL_CONTROL = 16'h0010;
  localparam logic [15:0] ADDR_RESERVED_DIRECT_A      = 16'h0011;
  localparam logic [15:0] ADDR_CONFIG_PRIMARY         = 16'h0012;
  localparam logic [15:0] ADDR_CONFIG_SECONDARY       = 16'h0013;
  localparam logic [15:0] ADDR_RESULT_HIGH            = 16'h0014;
  localparam logic [15:0] ADDR_RESULT_LOW             = 16'h0015;
  // high-page registers
  localparam logic [15:0] ADDR_COMPARE_VALUE_HIGH     = 16'h1880;
  localparam logic [15:0] ADDR_COMPARE_VALUE_LOW      = 16'h1881;
  localparam logic [15:0] ADDR_RESERVED_HIGH_A        = 16'h1882;
  localparam logic [15:0] ADDR_RESERVED_HIGH_B        = 16'h1883;
  localparam logic [15:0] ADDR_GEN_STATUS_CONTROL_TWO = 16'h1884;
  localparam logic [15:0] ADDR_GEN_STATUS_CONTROL_THR = 16'h1885;
  localparam logic [15:0] ADDR_PIN_ENABLE_LOW         = 16'h189F;
  localparam logic [15:0] ADDR_PIN_ENABLE_HIGH        = 16'h18A0;

  // status_channel_control fields
  localparam int BIT_CONVERSION_COMPLETE   = 7;
  localparam int BIT_CONV_INTERRUPT_ENABLE = 6;
  localparam int CHANNEL_MSB               = 4;
  localparam logic [4:0] CHANNEL_DISABLED  = 5'h1F;
  // general_status_control_two fields
  localparam int BIT_CONVERSION_ACTIVE     = 7;
  localparam int BIT_HARDWARE_TRIGGER      = 6;
  localparam int BIT_COMPARE_ENABLE        = 5;
  localparam int BIT_COMPARE_GREATER       = 4;
  // general_status_control_three fields
  localparam int BIT_CONTINUOUS_ENABLE     = 3;
  // config_secondary fields
  localparam int BIT_ASYNC_PREENABLE       = 3;
  localparam int BIT_HIGH_SPEED            = 2;
  localparam logic [3:0] CFG2_WRITE_MASK   = 4'hF;
  // config_primary fields
  localparam int BIT_LOW_POWER             = 7;
  localparam int BIT_LONG_SAMPLE           = 4;
  localparam logic [1:0] CLOCK_SELECT_ASYNC = 2'h3;
  localparam logic [1:0] MODE_8BIT         = 2'h0;
  localparam logic [1:0] MODE_12BIT        = 2'h1;
  localparam logic [1:0] MODE_10BIT        = 2'h2;

  // reset values
  localparam logic [7:0] RESET_STATUS_CHANNEL = 8'h1F;
  localparam logic [7:0] RESET_ZERO           = 8'h00;
  localparam logic [3:0] RESET_CFG2           = 4'h0;

  // asynchronous clock startup time, least time, rounded up
  localparam int CLOCK_PERIOD_NS    = 100;
  localparam int ASYNC_STARTUP_NS   = 5000;
  localparam int ASYNC_STARTUP_CYC  = (ASYNC_STARTUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam logic [7:0] STARTUP_COUNT = 8'(ASYNC_STARTUP_CYC);

  typedef enum {ST_IDLE, ST_STARTUP, ST_CONVERT} acr_state_type;

  // settings handed to the analog core
  typedef struct packed {
    logic [4:0]  channel;
    logic        low_power_config;
    logic [1:0]  clock_divide;
    logic        long_sample_enable;
    logic [1:0]  mode;
    logic [1:0]  input_clock_select;
    logic        async_clock_preenable;
    logic        high_speed_config;
    logic [1:0]  long_sample_time_select;
    logic [15:0] analog_pin_enable;
  } acr_core_cfg_type;

  // processor register access
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } acr_reg_req_type;

endpackage

/* rtl/acr_control.sv */
// acr_control: register map and conversion sequencer of the 12-bit converter
`timescale 1ns/100ps
//
// Operation
// RQ1 - channel control at 0x0010: complete flag bit 7, interrupt enable 6, channel low.
// RQ2 - continuous conversion bit lives in general control three at 0x1885.
// RQ3 - general control two at 0x1884: active, trigger, compare enable, greater-than.
// RQ4 - software keeps bit 3 and other reserved bits of 0x1884 at zero.
// RQ5 - sixteen-bit result: upper byte at 0x0014, lower byte at 0x0015.
// RQ6 - sixteen-bit compare value held at 0x1880 upper and 0x1881 lower.
// RQ7 - config registers at 0x0012 and 0x0013; first holds power, divide, sample, mode, clock.
// RQ8 - second config selects high speed and long sample time in low four bits.
// RQ9 - async clock pre-enabled skips the startup time on the first conversion.
// RQ10 - pin enables at 0x189F and 0x18A0, one bit per channel 0 to 15.
// RQ11 - init-only registers in high page, frequent ones in direct page.
// RQ12 - second config reset: async clock off, normal sequence, longest sample time.
// RQ13 - reserved 0x0011, 0x1882, 0x1883 read zero and ignore writes, no error.
module acr_control (
  // clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_n,
  // processor register port
  input  wire acr_pkg::acr_reg_req_type  reg_req,
  output logic [7:0]                     reg_rdata,
  // hardware trigger from on-chip logic, same clock
  input  wire logic                      hw_trigger,
  // analog core
  output logic                           core_start,
  output acr_pkg::acr_core_cfg_type      core_cfg,
  input  wire logic                      core_done,
  input  wire logic [11:0]               core_data,
  // completion request level
  output logic                           conversion_irq
);

  typedef struct packed {
    acr_pkg::acr_state_type state;
    logic [7:0]  startup_cnt;
    logic        start;
    logic        conversion_complete_flag;
    logic        conversion_interrupt_enable;
    logic [4:0]  channel;
    logic        hw_trig_sel;
    logic        cmp_en;
    logic        cmp_gt;
    logic        continuous;
    logic [7:0]  cfg1;
    logic [3:0]  cfg2;
    logic [15:0] result;
    logic [15:0] compare;
    logic [15:0] pin_en;
    logic [7:0]  rdata;
  } acr_regs_type;

  acr_regs_type r_q;
  acr_regs_type r_d;

  logic        wr_sc1;
  logic        want_start;
  logic        async_sel;
  logic [15:0] scaled;
  logic        cmp_true;

  //////////////////////////////////////////////////////////////////////////////
  // decode and helpers

  assign wr_sc1    = reg_req.wr && reg_req.addr == acr_pkg::ADDR_STATUS_CHANNEL_CONTROL;
  assign async_sel = r_q.cfg1[1:0] == acr_pkg::CLOCK_SELECT_ASYNC;

  // right-justify the core result to the selected resolution
  always_comb begin
    case (r_q.cfg1[3:2])
      acr_pkg::MODE_8BIT:  scaled = {8'h00, core_data[11:4]};
      acr_pkg::MODE_10BIT: scaled = {6'h00, core_data[11:2]};
      default:             scaled = {4'h0, core_data};
    endcase
  end

  // greater-than selects result >= compare, otherwise result < compare
  assign cmp_true = r_q.cmp_gt ? (scaled >= r_q.compare) : (scaled < r_q.compare);

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    r_d       = r_q;
    r_d.start = 1'b0;
    want_start = 1'b0;

    // register writes; reserved addresses fall through untouched (no error)
    if (reg_req.wr) begin
      case (reg_req.addr)  // RQ11
        acr_pkg::ADDR_STATUS_CHANNEL_CONTROL: begin  // RQ1
          r_d.conversion_interrupt_enable    = reg_req.wdata[acr_pkg::BIT_CONV_INTERRUPT_ENABLE];
          r_d.channel = reg_req.wdata[acr_pkg::CHANNEL_MSB:0];
          r_d.conversion_complete_flag    = 1'b0;
        end
        acr_pkg::ADDR_CONFIG_PRIMARY:   r_d.cfg1 = reg_req.wdata;  // RQ7
        acr_pkg::ADDR_CONFIG_SECONDARY: r_d.cfg2 = reg_req.wdata[3:0] & acr_pkg::CFG2_WRITE_MASK;  // RQ8
        acr_pkg::ADDR_COMPARE_VALUE_HIGH: r_d.compare[15:8] = reg_req.wdata;  // RQ6
        acr_pkg::ADDR_COMPARE_VALUE_LOW:  r_d.compare[7:0]  = reg_req.wdata;  // RQ6
        acr_pkg::ADDR_GEN_STATUS_CONTROL_TWO: begin  // RQ3
          // active bit is read-only; low nibble is reserved and dropped
          r_d.hw_trig_sel = reg_req.wdata[acr_pkg::BIT_HARDWARE_TRIGGER];
          r_d.cmp_en      = reg_req.wdata[acr_pkg::BIT_COMPARE_ENABLE];
          r_d.cmp_gt      = reg_req.wdata[acr_pkg::BIT_COMPARE_GREATER];
        end
        acr_pkg::ADDR_GEN_STATUS_CONTROL_THR:  // RQ2
          r_d.continuous = reg_req.wdata[acr_pkg::BIT_CONTINUOUS_ENABLE];
        acr_pkg::ADDR_PIN_ENABLE_LOW:  r_d.pin_en[7:0]  = reg_req.wdata;  // RQ10
        acr_pkg::ADDR_PIN_ENABLE_HIGH: r_d.pin_en[15:8] = reg_req.wdata;  // RQ10
        default: ;  // RQ13
      endcase
    end

    // reading the low result byte acknowledges the completion
    if (reg_req.rd && reg_req.addr == acr_pkg::ADDR_RESULT_LOW) begin
      r_d.conversion_complete_flag = 1'b0;
    end

    // a channel-control write aborts any conversion in flight
    if (wr_sc1) begin
      r_d.state = acr_pkg::ST_IDLE;
      if (!r_d.hw_trig_sel && r_d.channel != acr_pkg::CHANNEL_DISABLED) begin
        want_start = 1'b1;
      end
    end else if (r_q.state == acr_pkg::ST_IDLE && r_q.hw_trig_sel && hw_trigger
                 && r_q.channel != acr_pkg::CHANNEL_DISABLED) begin
      want_start = 1'b1;
    end

    case (r_q.state)
      acr_pkg::ST_STARTUP: begin
        if (!wr_sc1) begin
          if (r_q.startup_cnt <= 8'h01) begin
            r_d.state = acr_pkg::ST_CONVERT;
            r_d.start = 1'b1;
          end else begin
            r_d.startup_cnt = r_q.startup_cnt - 8'h01;
          end
        end
      end
      acr_pkg::ST_CONVERT: begin
        if (!wr_sc1 && core_done) begin
          // compare miss discards the sample and leaves the flag alone
          if (!r_q.cmp_en || cmp_true) begin
            r_d.result = scaled;  // RQ5
            r_d.conversion_complete_flag   = 1'b1;    // set wins over a result-read clear in this cycle
          end
          if (r_q.continuous) begin  // RQ2
            r_d.start = 1'b1;
          end else begin
            r_d.state = acr_pkg::ST_IDLE;
          end
        end
      end
      acr_pkg::ST_IDLE: ;
      default: r_d.state = acr_pkg::ST_IDLE;
    endcase

    // async clock that was not pre-enabled must first start up
    if (want_start) begin
      if (async_sel && !r_q.cfg2[acr_pkg::BIT_ASYNC_PREENABLE]) begin
        r_d.state       = acr_pkg::ST_STARTUP;
        r_d.startup_cnt = acr_pkg::STARTUP_COUNT;
      end else begin  // RQ9
        r_d.state = acr_pkg::ST_CONVERT;
        r_d.start = 1'b1;
      end
    end

    // read data, registered
    r_d.rdata = acr_pkg::RESET_ZERO;
    if (reg_req.rd) begin
      case (reg_req.addr)
        acr_pkg::ADDR_STATUS_CHANNEL_CONTROL:
          r_d.rdata = {r_q.conversion_complete_flag, r_q.conversion_interrupt_enable, 1'b0, r_q.channel};  // RQ1
        acr_pkg::ADDR_CONFIG_PRIMARY:   r_d.rdata = r_q.cfg1;
        acr_pkg::ADDR_CONFIG_SECONDARY: r_d.rdata = {4'h0, r_q.cfg2};
        acr_pkg::ADDR_RESULT_HIGH:      r_d.rdata = r_q.result[15:8];  // RQ5
        acr_pkg::ADDR_RESULT_LOW:       r_d.rdata = r_q.result[7:0];   // RQ5
        acr_pkg::ADDR_COMPARE_VALUE_HIGH: r_d.rdata = r_q.compare[15:8];
        acr_pkg::ADDR_COMPARE_VALUE_LOW:  r_d.rdata = r_q.compare[7:0];
        acr_pkg::ADDR_GEN_STATUS_CONTROL_TWO:  // RQ3
          r_d.rdata = {r_q.state != acr_pkg::ST_IDLE, r_q.hw_trig_sel, r_q.cmp_en, r_q.cmp_gt, 4'h0};
        acr_pkg::ADDR_GEN_STATUS_CONTROL_THR: r_d.rdata = {4'h0, r_q.continuous, 3'h0};
        acr_pkg::ADDR_PIN_ENABLE_LOW:   r_d.rdata = r_q.pin_en[7:0];
        acr_pkg::ADDR_PIN_ENABLE_HIGH:  r_d.rdata = r_q.pin_en[15:8];
        default: r_d.rdata = acr_pkg::RESET_ZERO;  // RQ13
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q.state       <= acr_pkg::ST_IDLE;
      r_q.startup_cnt <= 8'h00;
      r_q.start       <= 1'b0;
      r_q.conversion_complete_flag        <= 1'b0;
      r_q.conversion_interrupt_enable        <= 1'b0;
      r_q.channel     <= acr_pkg::RESET_STATUS_CHANNEL[acr_pkg::CHANNEL_MSB:0];
      r_q.hw_trig_sel <= 1'b0;
      r_q.cmp_en      <= 1'b0;
      r_q.cmp_gt      <= 1'b0;
      r_q.continuous  <= 1'b0;
      r_q.cfg1        <= acr_pkg::RESET_ZERO;
      r_q.cfg2        <= acr_pkg::RESET_CFG2;  // RQ12
      r_q.result      <= 16'h0000;
      r_q.compare     <= 16'h0000;
      r_q.pin_en      <= 16'h0000;
      r_q.rdata       <= acr_pkg::RESET_ZERO;
    end else begin
      r_q <= r_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata      = r_q.rdata;
  assign core_start     = r_q.start;
  assign conversion_irq = r_q.conversion_complete_flag & r_q.conversion_interrupt_enable;

  // core settings straight from the register flops
  always_comb begin
    core_cfg.channel                 = r_q.channel;
    core_cfg.low_power_config        = r_q.cfg1[acr_pkg::BIT_LOW_POWER];
    core_cfg.clock_divide            = r_q.cfg1[6:5];
    core_cfg.long_sample_enable      = r_q.cfg1[acr_pkg::BIT_LONG_SAMPLE];
    core_cfg.mode                    = r_q.cfg1[3:2];
    core_cfg.input_clock_select      = r_q.cfg1[1:0];
    core_cfg.async_clock_preenable   = r_q.cfg2[acr_pkg::BIT_ASYNC_PREENABLE];
    core_cfg.high_speed_config       = r_q.cfg2[acr_pkg::BIT_HIGH_SPEED];  // RQ8
    core_cfg.long_sample_time_select = r_q.cfg2[1:0];
    core_cfg.analog_pin_enable       = r_q.pin_en;  // RQ10
  end

endmodule // acr_control

/* test/acr_control_monitor.sv */
// acr_control_monitor: port-level checks of the converter control block
`timescale 1ns/100ps
module acr_control_monitor (
  // clock and reset
  input wire logic                      clk,
  input wire logic                      rst_n,
  // register port
  input wire acr_pkg::acr_reg_req_type  reg_req,
  input wire logic [7:0]                reg_rdata,
  // conversion side
  input wire logic                      hw_trigger,
  input wire logic                      core_start,
  input wire acr_pkg::acr_core_cfg_type core_cfg,
  input wire logic                      core_done,
  input wire logic [11:0]               core_data,
  input wire logic                      conversion_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // a write to one address, and a result read that no completion overrides
  sequence s_wr(logic [15:0] a);
    reg_req.wr && reg_req.addr == a;
  endsequence
  sequence s_low_read;
    reg_req.rd && reg_req.addr == acr_pkg::ADDR_RESULT_LOW && !core_done;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  AST_RESET_IDLE: assert property ($rose(rst_n) |-> !core_start && reg_rdata == 8'h00 && !conversion_irq
    && core_cfg.channel == 5'h1F && {core_cfg.async_clock_preenable, core_cfg.high_speed_config,
    core_cfg.long_sample_time_select} == 4'h0) else $error("outputs not idle after reset");
  AST_RESERVED_ZERO: assert property (reg_req.rd && (reg_req.addr == 16'h0011 || reg_req.addr == 16'h1882
    || reg_req.addr == 16'h1883) |=> reg_rdata == 8'h00) else $error("reserved place read nonzero");
  AST_CHANNEL_FIELD: assert property (s_wr(16'h0010) |=> core_cfg.channel == 5'($past(reg_req.wdata)))
    else $error("channel field not taken");
  AST_CFG1_FIELDS: assert property (s_wr(16'h0012) |=> {core_cfg.low_power_config, core_cfg.clock_divide,
    core_cfg.long_sample_enable, core_cfg.mode, core_cfg.input_clock_select} == $past(reg_req.wdata))
    else $error("primary config not taken");
  AST_CFG2_FIELDS: assert property (s_wr(16'h0013) |=> {core_cfg.async_clock_preenable,
    core_cfg.high_speed_config, core_cfg.long_sample_time_select} == 4'($past(reg_req.wdata)))
    else $error("secondary config not taken");
  AST_PIN_LOW: assert property (s_wr(16'h189F) |=> core_cfg.analog_pin_enable[7:0] == $past(reg_req.wdata))
    else $error("low pin enables not taken");
  AST_PIN_HIGH: assert property (s_wr(16'h18A0) |=> core_cfg.analog_pin_enable[15:8] == $past(reg_req.wdata))
    else $error("high pin enables not taken");
  AST_FLAG_CLEAR: assert property (s_low_read |=> !conversion_irq) else $error("flag kept after result read");
  AST_IRQ_HOLDS: assert property (conversion_irq && !(reg_req.wr && reg_req.addr == 16'h0010)
    && !(reg_req.rd && reg_req.addr == 16'h0015) |=> conversion_irq) else $error("flag dropped on its own");
endmodule // acr_control_monitor

bind acr_control acr_control_monitor u_acr_control_monitor (.clk(clk), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .hw_trigger(hw_trigger), .core_start(core_start), .core_cfg(core_cfg),
  .core_done(core_done), .core_data(core_data), .conversion_irq(conversion_irq));

/* test/test_acr_control.sv */
// test_acr_control: self-checking bench for the converter control block
`timescale 1ns/100ps
module test_acr_control;
  logic clk, rst_n, hw_trig, start, done, irq, pend;
  acr_pkg::acr_reg_req_type  req;
  acr_pkg::acr_core_cfg_type cfg;
  logic [7:0]  rdata, v, exp_q[$];
  logic [11:0] data, rnd;
  int          n_fail, total_checks, n_start;
  logic [15:0] adr[12] = '{16'h0012, 16'h0013, 16'h1880, 16'h1881, 16'h1884, 16'h1885, 16'h189F, 16'h18A0,
                           16'h0011, 16'h1882, 16'h1883, 16'h0014};
  logic [7:0]  msk[12] = '{8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h70, 8'h08, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};

  acr_control u_acr_control (.clk(clk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .hw_trigger(hw_trig),
    .core_start(start), .core_cfg(cfg), .core_done(done), .core_data(data), .conversion_irq(irq));

  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic wrap_up();
    if (n_fail == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one strobed access, then an idle cycle so strobes never get two values in one step
  task automatic acc(input logic [15:0] a, input logic [7:0] d, input logic w, input logic r);
    req <= '{addr: a, wr: w, rd: r, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    acc(a, 8'h00, 1'b0, 1'b1);
  endtask
  // one conversion on channel 5 with interrupt on; c says continuous mode is set
  task automatic convert(input logic [1:0] m, input int c);
    int b;
    logic [15:0] r;
    b = n_start;
    rnd = 12'($urandom);
    r = (m == 2'h0) ? {8'h00, rnd[11:4]} : (m == 2'h2) ? {6'h00, rnd[11:2]} : {4'h0, rnd};
    acc(16'h0010, 8'h45, 1'b1, 1'b0);
    @(posedge clk);
    chk(n_start, b + 1);
    done <= 1'b1;
    data <= rnd;
    @(posedge clk);
    done <= 1'b0;
    data <= ~rnd;
    @(posedge clk);
    chk(irq, 1'b1);
    rd(16'h0010, 8'hC5);
    chk(n_start, b + 1 + c);
    rd(16'h0014, r[15:8]);
    rd(16'h0015, r[7:0]);
    rd(16'h0010, 8'h45);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // read monitor: data stands the cycle after the strobe, so compare one edge later
  always @(posedge clk) begin
    if (pend) chk(rdata, exp_q.pop_front());
    pend <= req.rd;
    if (start) n_start <= n_start + 1;
  end
  // watchdog, far beyond the few hundred cycles the sequence needs
  initial begin
    #500000;
    n_fail++;
    wrap_up();
  end
  // main sequence
  initial begin
    int b;
    clk = 0; rst_n = 0; req = '0; hw_trig = 0; done = 0; data = 12'h000; pend = 0;
    n_fail = 0; total_checks = 0; n_start = 0;
    void'($urandom(91));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(16'h0010, 8'h1F);
    rd(16'h0013, 8'h00);
    chk(cfg.analog_pin_enable, 16'h0000);
    // writable, read-only and reserved places; masks drop bits that read as zero
    foreach (adr[i]) begin
      v = 8'($urandom);
      acc(adr[i], (adr[i] == 16'h1884) ? (v & 8'hF0) : v, 1'b1, 1'b0);
      rd(adr[i], v & msk[i]);
    end
    acc(16'h1884, 8'h00, 1'b1, 1'b0);
    acc(16'h1885, 8'h00, 1'b1, 1'b0);
    acc(16'h0013, 8'h00, 1'b1, 1'b0);
    for (int m = 0; m < 4; m++) begin
      acc(16'h0012, {4'h0, 2'(m), 2'h0}, 1'b1, 1'b0);
      convert(2'(m), 0);
    end
    acc(16'h1885, 8'h08, 1'b1, 1'b0);
    convert(2'h1, 1);
    // hardware trigger: a channel write must not start, the trigger pulse must
    acc(16'h1885, 8'h00, 1'b1, 1'b0);
    acc(16'h1884, 8'h40, 1'b1, 1'b0);
    b = n_start;
    acc(16'h0010, 8'h05, 1'b1, 1'b0);
    hw_trig <= 1'b1;
    @(posedge clk);
    hw_trig <= 1'b0;
    repeat (2) @(posedge clk);
    chk(n_start, b + 1);
    rd(16'h1884, 8'hC0);
    // async clock: pre-enabled starts at once, otherwise after the startup wait
    acc(16'h1884, 8'h00, 1'b1, 1'b0);
    acc(16'h0012, 8'h07, 1'b1, 1'b0);
    acc(16'h0013, 8'h08, 1'b1, 1'b0);
    b = n_start;
    acc(16'h0010, 8'h05, 1'b1, 1'b0);
    @(posedge clk);
    chk(n_start, b + 1);
    acc(16'h0013, 8'h00, 1'b1, 1'b0);
    acc(16'h0010, 8'h05, 1'b1, 1'b0);
    repeat (20) @(posedge clk);
    chk(n_start, b + 1);
    repeat (40) @(posedge clk);
    chk(n_start, b + 2);
    // compare function: bit 11 of the code puts it either side of 0x0800, kept only on a hit
    acc(16'h0012, 8'h04, 1'b1, 1'b0);
    acc(16'h1880, 8'h08, 1'b1, 1'b0);
    acc(16'h1881, 8'h00, 1'b1, 1'b0);
    for (int g = 0; g < 2; g++) begin
      acc(16'h1884, {3'h1, 1'(g), 4'h0}, 1'b1, 1'b0);
      for (int k = 0; k < 2; k++) begin
        rnd = {1'(k), 11'($urandom)};
        acc(16'h0010, 8'h45, 1'b1, 1'b0);
        done <= 1'b1;
        data <= rnd;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
        chk(irq, k == g);
        if (k == g) begin
          rd(16'h0014, {4'h0, rnd[11:8]});
          rd(16'h0015, rnd[7:0]);
        end
      end
    end
    wrap_up();
  end
endmodule // test_acr_control
